// [mifc_defines.vh]
// Constants of the interrupt flag and enable block: register offsets,
// bit positions, edge codes, vector codes and timing figures.
// Assumes inclusion by bare name from the controller and the testbench.
`ifndef MIFC_DEFINES_VH
`define MIFC_DEFINES_VH

// Register byte offsets on the AHB-Lite slave
`define MIFC_OFS_EDGE 8'h00
`define MIFC_OFS_PRI 8'h04
`define MIFC_OFS_SEC 8'h08
`define MIFC_OFS_GRP 8'h0c
`define MIFC_OFS_STAT 8'h10
`define MIFC_OFS_MASK 8'h14
`define MIFC_OFS_LVDLY 8'h18

// Implemented bit masks of each register
`define MIFC_EDGE_MASK 8'h03
`define MIFC_PRI_MASK 8'h7f
`define MIFC_SEC_MASK 8'hff
`define MIFC_GRP_MASK 8'hff
`define MIFC_EVT_MASK 8'h07
`define MIFC_LVDLY_MASK 8'h03

// Primary control register fields
`define MIFC_PRI_GIE 0
`define MIFC_PRI_PIN_EN 1
`define MIFC_PRI_TBA_EN 2
`define MIFC_PRI_TOUCH_EN 3
`define MIFC_PRI_PIN_F 4
`define MIFC_PRI_TBA_F 5
`define MIFC_PRI_TOUCH_F 6

// Second control register fields
`define MIFC_SEC_CA_EN 0
`define MIFC_SEC_CB_EN 1
`define MIFC_SEC_TW_EN 2
`define MIFC_SEC_GRP_EN 3
`define MIFC_SEC_CA_F 4
`define MIFC_SEC_CB_F 5
`define MIFC_SEC_TW_F 6
`define MIFC_SEC_GRP_F 7

// Group control register fields
`define MIFC_GRP_MP_EN 0
`define MIFC_GRP_MA_EN 1
`define MIFC_GRP_TBB_EN 2
`define MIFC_GRP_LV_EN 3
`define MIFC_GRP_MP_F 4
`define MIFC_GRP_MA_F 5
`define MIFC_GRP_TBB_F 6
`define MIFC_GRP_LV_F 7

// Enable-to-flag distance inside the second and group control registers
`define MIFC_FLAG_SHIFT 4

// Pin edge field codes
`define MIFC_EDGE_OFF 2'b00
`define MIFC_EDGE_RISE 2'b01
`define MIFC_EDGE_FALL 2'b10
`define MIFC_EDGE_BOTH 2'b11

// Vector codes, highest priority first
`define MIFC_VEC_PIN 3'h0
`define MIFC_VEC_TOUCH 3'h1
`define MIFC_VEC_TBA 3'h2
`define MIFC_VEC_CA 3'h3
`define MIFC_VEC_CB 3'h4
`define MIFC_VEC_TW 3'h5
`define MIFC_VEC_GRP 3'h6

// Event status bits
`define MIFC_EVT_TAKEN 0
`define MIFC_EVT_LV 1
`define MIFC_EVT_PIN 2

// AHB codes
`define MIFC_HSIZE_WORD 3'b010
`define MIFC_RESET_BYTE 8'h00

// Timing: system clock period and slow oscillator period
`define MIFC_CLK_PERIOD_NS 5
`define MIFC_LIRC_PERIOD_NS 31250
// Lowvolt delay base count in slow periods, doubled per select step
`define MIFC_LV_BASE_TICKS 5'h02

`endif

// [mifc_pin_edge.v]
// Two-flop synchroniser with rising and falling edge pulses.
// Assumes an asynchronous input and a free-running hclk.
`timescale 1ns/1ps
module mifc_pin_edge (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Asynchronous pin
	input wire pin_async,
	// Synchronised level and edge pulses
	output wire level,
	output wire rise,
	output wire fall
);

reg sync_a;
reg sync_b;
reg prev;

// First flop feeds only the second; edges compare second and third
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		sync_a <= 1'b0;
		sync_b <= 1'b0;
		prev <= 1'b0;
	end else begin
		sync_a <= pin_async;
		sync_b <= sync_a;
		prev <= sync_b;
	end
end

// Edge pulses last one cycle
assign level = sync_b;
assign rise = sync_b & ~prev;
assign fall = ~sync_b & prev;

endmodule // mifc_pin_edge

// [mifc_irq_ctrl.v]
// Interrupt request flags, enables, priority and vector hand-off.
// Assumes source events are one-cycle pulses on hclk, the pin and the
// lowvolt signal are asynchronous, and a single AHB-Lite master.
//
// Notes on behaviour
// - Two-bit pin edge field: off, rising, falling, or both edges.
// - Pin flag sets on a synchronised pin edge of selected type.
// - Taken enabled request diverts the core to that source's service.
// - Global enable in primary bit 0 gates every request to the core.
// - Each source has a pending flag and a separate enable bit.
// - Some sources have own vectors; the rest share the group vector.
// - Group register holds member flags; aggregate sits in second register.
// - Edge-select bits 7 to 2 read zero.
// - Touch flag bit 6, enable bit 3; primary bit 7 reads zero.
// - Timebase A flag bit 5, enable bit 2 of primary register.
// - Pin flag bit 4, enable bit 1 of primary register.
// - Counter A/B flags bits 4/5, enables bits 0/1, second register.
// - Internal source events raise their own flags.
// - Bits named by source, optional instance, then enable or flag.
// - Lowvolt flag sets after selectable delay and wakes from idle.
`timescale 1ns/1ps
`include "mifc_defines.vh"
module mifc_irq_ctrl #(
	parameter LIRC_CYCLES = `MIFC_LIRC_PERIOD_NS / `MIFC_CLK_PERIOD_NS,
	parameter DIV_W = 16
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// Asynchronous inputs
	input wire ext_pin,
	input wire lowvolt_out,
	// Source event pulses
	input wire touch_event,
	input wire timebase_a_event,
	input wire timebase_b_event,
	input wire counter_a_event,
	input wire counter_b_event,
	input wire twowire_event,
	input wire match_a_event,
	input wire match_p_event,
	// Core interface
	output reg cpu_irq_req,
	output reg [2:0] cpu_irq_vector,
	input wire cpu_irq_ack,
	// System outputs
	output reg wake_from_idle,
	output reg irq
);

// Register state
reg [7:0] edge_select_reg;
reg [7:0] primary_control_reg;
reg [7:0] second_control_reg;
reg [7:0] group_control_reg;
reg [7:0] event_status;
reg [7:0] event_mask;
reg [7:0] lowvolt_delay_sel;
reg [7:0] next_edge;
reg [7:0] next_pri;
reg [7:0] next_sec;
reg [7:0] next_grp;
reg [7:0] next_stat;
reg [7:0] next_mask;
reg [7:0] next_lvdly;

// Bus data-phase state
reg wr_pend;
reg [7:0] wr_addr;

// Lowvolt delay state
reg [DIV_W-1:0] lirc_div;
reg lirc_tick;
reg [4:0] lv_ticks;
reg lv_done;

// Pin and lowvolt synchronisers
wire pin_level;
wire pin_rise;
wire pin_fall;
wire lv_level;

mifc_pin_edge u_pin (
	.hclk(hclk),
	.hresetn(hresetn),
	.pin_async(ext_pin),
	.level(pin_level),
	.rise(pin_rise),
	.fall(pin_fall)
);

mifc_pin_edge u_lv (
	.hclk(hclk),
	.hresetn(hresetn),
	.pin_async(lowvolt_out),
	.level(lv_level),
	.rise(),
	.fall()
);

// Single-cycle slave, never an error
assign hreadyout = 1'b1;
assign hresp = 1'b0;

// Address phase: writes are taken only as whole words, reads of any size
wire addr_take = hsel & htrans[1] & hready;
wire wr_take = addr_take & hwrite & (hsize == `MIFC_HSIZE_WORD);
wire rd_take = addr_take & ~hwrite;
wire [7:0] wd = hwdata[7:0];

// Write strobes, decoded from the held data-phase address
wire wr_edge = wr_pend && (wr_addr == `MIFC_OFS_EDGE);
wire wr_pri = wr_pend && (wr_addr == `MIFC_OFS_PRI);
wire wr_sec = wr_pend && (wr_addr == `MIFC_OFS_SEC);
wire wr_grp = wr_pend && (wr_addr == `MIFC_OFS_GRP);
wire wr_stat = wr_pend && (wr_addr == `MIFC_OFS_STAT);
wire wr_mask = wr_pend && (wr_addr == `MIFC_OFS_MASK);
wire wr_lvdly = wr_pend && (wr_addr == `MIFC_OFS_LVDLY);

// Pin edge qualification by the selected field
wire [1:0] pin_edge_field = edge_select_reg[1:0];
reg pin_hit;
always @* begin
	case (pin_edge_field)
	`MIFC_EDGE_RISE: pin_hit = pin_rise;
	`MIFC_EDGE_FALL: pin_hit = pin_fall;
	`MIFC_EDGE_BOTH: pin_hit = pin_rise | pin_fall;
	default: pin_hit = 1'b0;
	endcase
end

// Slow-clock tick from a divider; the delay counts slow periods
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		lirc_div <= {DIV_W{1'b0}};
		lirc_tick <= 1'b0;
	end else if (lirc_div == LIRC_CYCLES[DIV_W-1:0] - 1'b1) begin
		lirc_div <= {DIV_W{1'b0}};
		lirc_tick <= 1'b1;
	end else begin
		lirc_div <= lirc_div + 1'b1;
		lirc_tick <= 1'b0;
	end
end

// Delay target doubles per step: 2, 4, 8 or 16 slow periods
wire [4:0] lv_target = `MIFC_LV_BASE_TICKS << lowvolt_delay_sel[1:0];
wire lv_fire = lv_level & ~lv_done & (lv_ticks >= lv_target);

// Low voltage must hold for the whole delay; a dip restarts it
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		lv_ticks <= 5'h00;
		lv_done <= 1'b0;
	end else if (!lv_level) begin
		lv_ticks <= 5'h00;
		lv_done <= 1'b0;
	end else if (lv_fire) begin
		lv_done <= 1'b1;
	end else if (lirc_tick && !lv_done && lv_ticks < lv_target) begin
		lv_ticks <= lv_ticks + 5'h01;
	end
end

// Hardware set terms per register
wire [7:0] pri_set;
wire [7:0] sec_set;
wire [7:0] grp_set;
wire grp_any;
assign grp_set = ({7'h00, match_p_event} << `MIFC_GRP_MP_F)
	| ({7'h00, match_a_event} << `MIFC_GRP_MA_F)
	| ({7'h00, timebase_b_event} << `MIFC_GRP_TBB_F)
	| ({7'h00, lv_fire} << `MIFC_GRP_LV_F);
// Aggregate group flag is set by any enabled member and holds until cleared
assign grp_any = |(group_control_reg[7:4] & group_control_reg[3:0]);
assign pri_set = ({7'h00, pin_hit} << `MIFC_PRI_PIN_F)
	| ({7'h00, timebase_a_event} << `MIFC_PRI_TBA_F)
	| ({7'h00, touch_event} << `MIFC_PRI_TOUCH_F);
assign sec_set = ({7'h00, counter_a_event} << `MIFC_SEC_CA_F)
	| ({7'h00, counter_b_event} << `MIFC_SEC_CB_F)
	| ({7'h00, twowire_event} << `MIFC_SEC_TW_F)
	| ({7'h00, grp_any} << `MIFC_SEC_GRP_F);

// Pending enabled requests, each flag sits four bits above its enable in the second register, three in the primary
wire [6:0] pend;
assign pend[`MIFC_VEC_PIN] = primary_control_reg[`MIFC_PRI_PIN_F] & primary_control_reg[`MIFC_PRI_PIN_EN];
assign pend[`MIFC_VEC_TOUCH] = primary_control_reg[`MIFC_PRI_TOUCH_F] & primary_control_reg[`MIFC_PRI_TOUCH_EN];
assign pend[`MIFC_VEC_TBA] = primary_control_reg[`MIFC_PRI_TBA_F] & primary_control_reg[`MIFC_PRI_TBA_EN];
assign pend[`MIFC_VEC_CA] = second_control_reg[`MIFC_SEC_CA_F] & second_control_reg[`MIFC_SEC_CA_EN];
assign pend[`MIFC_VEC_CB] = second_control_reg[`MIFC_SEC_CB_F] & second_control_reg[`MIFC_SEC_CB_EN];
assign pend[`MIFC_VEC_TW] = second_control_reg[`MIFC_SEC_TW_F] & second_control_reg[`MIFC_SEC_TW_EN];
// Group members share one vector through the aggregate flag
assign pend[`MIFC_VEC_GRP] = second_control_reg[`MIFC_SEC_GRP_F] & second_control_reg[`MIFC_SEC_GRP_EN];

// Fixed priority: lower vector code wins
reg [2:0] win_vec;
reg win_any;
always @* begin
	win_vec = `MIFC_VEC_PIN;
	win_any = 1'b1;
	if (pend[`MIFC_VEC_PIN]) begin
		win_vec = `MIFC_VEC_PIN;
	end else if (pend[`MIFC_VEC_TOUCH]) begin
		win_vec = `MIFC_VEC_TOUCH;
	end else if (pend[`MIFC_VEC_TBA]) begin
		win_vec = `MIFC_VEC_TBA;
	end else if (pend[`MIFC_VEC_CA]) begin
		win_vec = `MIFC_VEC_CA;
	end else if (pend[`MIFC_VEC_CB]) begin
		win_vec = `MIFC_VEC_CB;
	end else if (pend[`MIFC_VEC_TW]) begin
		win_vec = `MIFC_VEC_TW;
	end else if (pend[`MIFC_VEC_GRP]) begin
		win_vec = `MIFC_VEC_GRP;
	end else begin
		win_any = 1'b0;
	end
end

// Acknowledge clears the taken dedicated flag and the global enable;
// group members stay set for software, so the aggregate stays set while an enabled member flag remains
wire ack_ok = cpu_irq_ack & cpu_irq_req;
reg [7:0] pri_clr;
reg [7:0] sec_clr;
always @* begin
	pri_clr = 8'h00;
	sec_clr = 8'h00;
	if (ack_ok) begin
		pri_clr[`MIFC_PRI_GIE] = 1'b1;
		case (cpu_irq_vector)
		`MIFC_VEC_PIN: pri_clr[`MIFC_PRI_PIN_F] = 1'b1;
		`MIFC_VEC_TOUCH: pri_clr[`MIFC_PRI_TOUCH_F] = 1'b1;
		`MIFC_VEC_TBA: pri_clr[`MIFC_PRI_TBA_F] = 1'b1;
		`MIFC_VEC_CA: sec_clr[`MIFC_SEC_CA_F] = 1'b1;
		`MIFC_VEC_CB: sec_clr[`MIFC_SEC_CB_F] = 1'b1;
		`MIFC_VEC_TW: sec_clr[`MIFC_SEC_TW_F] = 1'b1;
		`MIFC_VEC_GRP: sec_clr[`MIFC_SEC_GRP_F] = 1'b1;
		default: sec_clr = 8'h00;
		endcase
	end
end

// Events for the sticky status register
wire [7:0] evt;
assign evt = ({7'h00, ack_ok} << `MIFC_EVT_TAKEN)
	| ({7'h00, lv_fire} << `MIFC_EVT_LV)
	| ({7'h00, pin_hit} << `MIFC_EVT_PIN);

// Next register values: write, then clear, then hardware set wins
always @* begin
	next_edge = wr_edge ? (wd & `MIFC_EDGE_MASK) : edge_select_reg;
	next_pri = (((wr_pri ? wd : primary_control_reg) & ~pri_clr) | pri_set) & `MIFC_PRI_MASK;
	next_sec = (((wr_sec ? wd : second_control_reg) & ~sec_clr) | sec_set) & `MIFC_SEC_MASK;
	next_grp = ((wr_grp ? wd : group_control_reg) | grp_set) & `MIFC_GRP_MASK;
	next_stat = ((event_status & ~(wr_stat ? wd : 8'h00)) | evt) & `MIFC_EVT_MASK;
	next_mask = wr_mask ? (wd & `MIFC_EVT_MASK) : event_mask;
	next_lvdly = wr_lvdly ? (wd & `MIFC_LVDLY_MASK) : lowvolt_delay_sel;
end

// Register update; every flag and enable starts cleared
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		edge_select_reg <= `MIFC_RESET_BYTE;
		primary_control_reg <= `MIFC_RESET_BYTE;
		second_control_reg <= `MIFC_RESET_BYTE;
		group_control_reg <= `MIFC_RESET_BYTE;
		event_status <= `MIFC_RESET_BYTE;
		event_mask <= `MIFC_RESET_BYTE;
		lowvolt_delay_sel <= `MIFC_RESET_BYTE;
	end else begin
		edge_select_reg <= next_edge;
		primary_control_reg <= next_pri;
		second_control_reg <= next_sec;
		group_control_reg <= next_grp;
		event_status <= next_stat;
		event_mask <= next_mask;
		lowvolt_delay_sel <= next_lvdly;
	end
end

// Core request uses post-update state, so an ack drops it at once
wire [6:0] next_pend;
assign next_pend[`MIFC_VEC_PIN] = next_pri[`MIFC_PRI_PIN_F] & next_pri[`MIFC_PRI_PIN_EN];
assign next_pend[`MIFC_VEC_TOUCH] = next_pri[`MIFC_PRI_TOUCH_F] & next_pri[`MIFC_PRI_TOUCH_EN];
assign next_pend[`MIFC_VEC_TBA] = next_pri[`MIFC_PRI_TBA_F] & next_pri[`MIFC_PRI_TBA_EN];
assign next_pend[`MIFC_VEC_CA] = next_sec[`MIFC_SEC_CA_F] & next_sec[`MIFC_SEC_CA_EN];
assign next_pend[`MIFC_VEC_CB] = next_sec[`MIFC_SEC_CB_F] & next_sec[`MIFC_SEC_CB_EN];
assign next_pend[`MIFC_VEC_TW] = next_sec[`MIFC_SEC_TW_F] & next_sec[`MIFC_SEC_TW_EN];
assign next_pend[`MIFC_VEC_GRP] = next_sec[`MIFC_SEC_GRP_F] & next_sec[`MIFC_SEC_GRP_EN];

// Vector follows the winner one cycle later; held in the ack cycle and while nothing is pending
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		cpu_irq_req <= 1'b0;
		cpu_irq_vector <= `MIFC_VEC_PIN;
	end else begin
		cpu_irq_req <= next_pri[`MIFC_PRI_GIE] & (|next_pend);
		if (win_any && !ack_ok) begin
			cpu_irq_vector <= win_vec;
		end
	end
end

// Level interrupt and wake pulse from flops
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		irq <= 1'b0;
		wake_from_idle <= 1'b0;
	end else begin
		irq <= |(next_stat & next_mask);
		wake_from_idle <= lv_fire;
	end
end

// Bus data phase bookkeeping
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_pend <= 1'b0;
		wr_addr <= 8'h00;
	end else begin
		wr_pend <= wr_take;
		wr_addr <= haddr[7:0];
	end
end

// Read data captured at the address phase from post-write values,
// so a read right after a write sees the new contents
// Field names follow source, optional instance, then enable or flag
reg [7:0] rd_byte;
always @* begin
	rd_byte = 8'h00;
	if (haddr[7:0] == `MIFC_OFS_EDGE) begin
		rd_byte = next_edge;
	end else if (haddr[7:0] == `MIFC_OFS_PRI) begin
		rd_byte = next_pri;
	end else if (haddr[7:0] == `MIFC_OFS_SEC) begin
		rd_byte = next_sec;
	end else if (haddr[7:0] == `MIFC_OFS_GRP) begin
		rd_byte = next_grp;
	end else if (haddr[7:0] == `MIFC_OFS_STAT) begin
		rd_byte = next_stat;
	end else if (haddr[7:0] == `MIFC_OFS_MASK) begin
		rd_byte = next_mask;
	end else if (haddr[7:0] == `MIFC_OFS_LVDLY) begin
		rd_byte = next_lvdly;
	end else begin
		rd_byte = 8'h00; // Unmapped reads zero
	end
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata <= 32'h00000000;
	end else if (rd_take) begin
		hrdata <= {24'h000000, rd_byte};
	end
end

endmodule // mifc_irq_ctrl

// [mifc_monitor.sv]
// Checker of the interrupt flag block, watching only its top ports.
// Assumes one free-running hclk and an asynchronous active-low hresetn.
`timescale 1ns/1ps
module mifc_monitor (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Bus
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	// Sources
	input wire ext_pin,
	input wire lowvolt_out,
	input wire touch_event,
	input wire timebase_a_event,
	input wire timebase_b_event,
	input wire counter_a_event,
	input wire counter_b_event,
	input wire twowire_event,
	input wire match_a_event,
	input wire match_p_event,
	// Core and system outputs
	input wire cpu_irq_req,
	input wire [2:0] cpu_irq_vector,
	input wire cpu_irq_ack,
	input wire wake_from_idle,
	input wire irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire wr = hsel & htrans[1] & hwrite & hready;
	wire ev = touch_event | timebase_a_event | timebase_b_event | counter_a_event | counter_b_event
		| twowire_event | match_a_event | match_p_event;
	reg [2:0] wr_h;
	reg [1:0] ev_h;
	reg [5:0] pin_h;
	reg wk_h;
	reg ack_h;
	// Low voltage as the second sync flop inside the block would see it
	reg [1:0] lv_h;
	wire lowvolt_seen = lv_h[1];
	// Cause history; the group aggregate lags its member by one edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_h <= 3'h0;
			ev_h <= 2'h0;
			pin_h <= 6'h00;
			wk_h <= 1'b0;
			ack_h <= 1'b0;
			lv_h <= 2'h0;
		end else begin
			lv_h <= {lv_h[0], lowvolt_out};
			wr_h <= {wr_h[1:0], wr};
			ev_h <= {ev_h[0], ev};
			pin_h <= {pin_h[4:0], ext_pin};
			wk_h <= wake_from_idle;
			ack_h <= cpu_irq_ack & cpu_irq_req;
		end
	end
	wire cause = (|ev_h) | wr_h[2] | wr_h[1] | (pin_h != 6'h00 && pin_h != 6'h3f) | wake_from_idle | wk_h;
	property p_upper_zero;
		hrdata[31:8] == 24'h000000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("hrdata upper bits set");
	property p_ack_drop;
		cpu_irq_ack && cpu_irq_req && !wr && !wr_h[0] |=> !cpu_irq_req [*2];
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("request stayed after ack");
	property p_req_cause;
		$rose(cpu_irq_req) |-> cause;
	endproperty
	a_req_cause: assert property (p_req_cause) else $error("request without cause");
	property p_irq_cause;
		$rose(irq) |-> cause || ack_h;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
	property p_wake_pulse;
		wake_from_idle |=> !wake_from_idle;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
	property p_wake_cause;
		wake_from_idle |-> $past(lowvolt_seen, 1);
	endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("wake without low voltage");
	property p_reset_quiet;
		$rose(hresetn) |-> !cpu_irq_req && !irq && !wake_from_idle;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	property p_vec_range;
		cpu_irq_req |-> cpu_irq_vector <= 3'h6;
	endproperty
	a_vec_range: assert property (p_vec_range) else $error("vector code out of range");
	input_hold_dummy: cover property (cpu_irq_ack && cpu_irq_req);
endmodule // mifc_monitor
bind mifc_irq_ctrl mifc_monitor mifc_monitor_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .ext_pin(ext_pin), .lowvolt_out(lowvolt_out),
	.touch_event(touch_event),
	.timebase_a_event(timebase_a_event), .timebase_b_event(timebase_b_event), .counter_a_event(counter_a_event),
	.counter_b_event(counter_b_event), .twowire_event(twowire_event), .match_a_event(match_a_event),
	.match_p_event(match_p_event), .cpu_irq_req(cpu_irq_req), .cpu_irq_vector(cpu_irq_vector),
	.cpu_irq_ack(cpu_irq_ack), .wake_from_idle(wake_from_idle), .irq(irq));

// [mifc_core_model.sv]
// Core model taking vectored requests with a chosen service latency.
// Assumes the block's one-cycle ack contract; lat of zero never acks.
`timescale 1ns/1ps
module mifc_core_model (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Service latency in cycles
	input wire [3:0] lat,
	// Interrupt hand-off
	input wire cpu_irq_req,
	input wire [2:0] cpu_irq_vector,
	output reg cpu_irq_ack,
	// Last serviced vector and count
	output reg [2:0] taken_vec,
	output reg [7:0] n_taken
);
	reg [3:0] cnt;
	// Waits at least one cycle so the vector has settled before acking
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_irq_ack <= 1'b0;
			taken_vec <= 3'h0;
			n_taken <= 8'h00;
			cnt <= 4'h0;
		end else if (cpu_irq_ack) begin
			cpu_irq_ack <= 1'b0;
			cnt <= 4'h0;
		end else if (cpu_irq_req && lat != 4'h0) begin
			if (cnt >= lat) begin
				cpu_irq_ack <= 1'b1;
				taken_vec <= cpu_irq_vector;
				n_taken <= n_taken + 8'h01;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end else begin
			cnt <= 4'h0;
		end
	end
endmodule // mifc_core_model

// [testbench.sv]
// Self-checking bench of the interrupt flag block with a core model.
// Assumes the block's header and a zero-wait AHB-Lite slave.
`timescale 1ns/1ps
`include "mifc_defines.vh"
module testbench;
	reg hclk;
	reg hresetn;
	reg hsel;
	reg [31:0] haddr;
	reg [1:0] htrans;
	reg hwrite;
	reg [2:0] hsize;
	reg [31:0] hwdata;
	reg ext_pin;
	reg lowvolt_out;
	reg [7:0] ev;
	reg [3:0] lat;
	reg [31:0] rv;
	wire hreadyout;
	wire hresp;
	wire [31:0] hrdata;
	wire cpu_irq_req;
	wire [2:0] cpu_irq_vector;
	wire cpu_irq_ack;
	wire wake_from_idle;
	wire irq;
	wire [2:0] taken_vec;
	wire [7:0] n_taken;
	integer n_errors;
	integer n_checks;
	integer cyc;
	integer e_pri;
	integer e_sec;
	integer e_grp;
	integer e_st;
	integer i;
	integer j;
	integer m;
	integer r;
	// Register and bit of each source flag, source index 0 to 7
	localparam [63:0] OFS = {8'h0c, 8'h0c, 8'h08, 8'h08, 8'h08, 8'h0c, 8'h04, 8'h04};
	localparam [23:0] BITS = {3'h4, 3'h5, 3'h6, 3'h5, 3'h4, 3'h6, 3'h5, 3'h6};

	mifc_irq_ctrl #(.LIRC_CYCLES(4)) mifc_irq_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_pin(ext_pin), .lowvolt_out(lowvolt_out),
		.touch_event(ev[0]), .timebase_a_event(ev[1]), .timebase_b_event(ev[2]), .counter_a_event(ev[3]),
		.counter_b_event(ev[4]), .twowire_event(ev[5]), .match_a_event(ev[6]), .match_p_event(ev[7]),
		.cpu_irq_req(cpu_irq_req), .cpu_irq_vector(cpu_irq_vector), .cpu_irq_ack(cpu_irq_ack),
		.wake_from_idle(wake_from_idle), .irq(irq));
	mifc_core_model mifc_core_model_i (.hclk(hclk), .hresetn(hresetn), .lat(lat), .cpu_irq_req(cpu_irq_req),
		.cpu_irq_vector(cpu_irq_vector), .cpu_irq_ack(cpu_irq_ack), .taken_vec(taken_vec), .n_taken(n_taken));

	// Clock
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	task complete_run;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask

	task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask

	// One single transfer; entered just after a rising edge
	task bus(input w, input [7:0] a, input [31:0] d, input [2:0] sz);
		begin
			hsel <= 1'b1;
			haddr <= {24'h000000, a};
			htrans <= 2'h2;
			hwrite <= w;
			hsize <= sz;
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			rv = hrdata;
		end
	endtask

	task wr(input [7:0] a, input [31:0] d);
		bus(1'b1, a, d, `MIFC_HSIZE_WORD);
	endtask

	task rd(input [7:0] a, input [31:0] e, input [63:0] nm);
		begin
			bus(1'b0, a, 32'h00000000, `MIFC_HSIZE_WORD);
			chk(nm, rv, e);
		end
	endtask

	// Hang guard, well above the few hundred cycles the tests take
	always @(posedge hclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			complete_run;
		end
	end

	initial begin
		{hsel, hwrite, ext_pin, lowvolt_out} = 4'h0;
		{haddr, hwdata} = 64'h0;
		{htrans, hsize, ev, lat} = 17'h0;
		{n_errors, n_checks, cyc, e_st} = 128'h0;
		hresetn = 1'b0;
		r = $urandom(32'hf4607cf0);
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 8; i = i + 1) rd({i[5:0], 2'b00}, 0, "reset");
		$display("test reset done");
		for (j = 0; j < 4; j = j + 1) begin
			r = $urandom;
			wr(`MIFC_OFS_EDGE, r);
			rd(`MIFC_OFS_EDGE, r & 3, "edge");
			wr(`MIFC_OFS_GRP, r);
			e_grp = r & 255;
			rd(`MIFC_OFS_GRP, e_grp, "group");
			wr(`MIFC_OFS_SEC, r >> 8);
			e_sec = ((r >> 8) & 255) | ((((e_grp >> 4) & e_grp & 15) != 0) ? 128 : 0);
			rd(`MIFC_OFS_SEC, e_sec, "second");
			wr(`MIFC_OFS_PRI, r >> 16);
			bus(1'b1, `MIFC_OFS_PRI, ~r, 3'h0);
			rd(`MIFC_OFS_PRI, (r >> 16) & 127, "primary");
		end
		wr(`MIFC_OFS_PRI, 0);
		wr(`MIFC_OFS_GRP, 0);
		wr(`MIFC_OFS_SEC, 0);
		$display("test registers done");
		for (i = 0; i < 8; i = i + 1) begin
			ev <= 8'h01 << i;
			@(posedge hclk);
			ev <= 8'h00;
			rd(OFS[i*8+:8], 1 << BITS[i*3+:3], "event");
			wr(OFS[i*8+:8], 0);
		end
		$display("test events done");
		wr(`MIFC_OFS_GRP, 15);
		wr(`MIFC_OFS_SEC, 15);
		wr(`MIFC_OFS_PRI, 15);
		ev <= 8'hff;
		@(posedge hclk);
		ev <= 8'h00;
		e_pri = 111;
		e_sec = 255;
		for (j = 1; j < 7; j = j + 1) begin
			m = n_taken;
			lat <= 1 + $urandom % 4;
			r = 0;
			while (n_taken == m && r < 50) begin
				@(posedge hclk);
				r = r + 1;
			end
			lat <= 4'h0;
			@(posedge hclk);
			chk("vector", taken_vec, j);
			e_pri = e_pri & 126;
			if (j < 3) e_pri = e_pri & ~(1 << (7 - j));
			else if (j < 6) e_sec = e_sec & ~(1 << (j + 1));
			e_st = e_st | 1;
			rd(`MIFC_OFS_PRI, e_pri, "primary");
			rd(`MIFC_OFS_SEC, e_sec, "second");
			if (j == 6) begin
				wr(`MIFC_OFS_GRP, 15);
				wr(`MIFC_OFS_SEC, 15);
				rd(`MIFC_OFS_SEC, 15, "second");
			end
			wr(`MIFC_OFS_PRI, e_pri | 1);
			e_pri = e_pri | 1;
		end
		$display("test priority done");
		wr(`MIFC_OFS_PRI, 2);
		for (m = 0; m < 4; m = m + 1) begin
			wr(`MIFC_OFS_EDGE, m);
			for (j = 0; j < 2; j = j + 1) begin
				ext_pin <= ~ext_pin;
				repeat (6) @(posedge hclk);
				rd(`MIFC_OFS_PRI, 2 | (((m >> j) & 1) << 4), "pin");
				wr(`MIFC_OFS_PRI, 2);
				e_st = e_st | (((m >> j) & 1) << 2);
			end
		end
		$display("test pin done");
		m = $urandom % 4;
		wr(`MIFC_OFS_LVDLY, m);
		wr(`MIFC_OFS_GRP, 8);
		lowvolt_out <= 1'b1;
		r = 0;
		while (wake_from_idle !== 1'b1 && r < 400) begin
			@(posedge hclk);
			r = r + 1;
		end
		chk("lvdelay", r >= ((2 << m) - 1) * 4 && r <= (2 << m) * 4 + 8, 1);
		lowvolt_out <= 1'b0;
		@(posedge hclk);
		rd(`MIFC_OFS_GRP, 136, "lvflag");
		rd(`MIFC_OFS_SEC, 143, "second");
		e_st = e_st | 2;
		wr(`MIFC_OFS_GRP, 0);
		wr(`MIFC_OFS_SEC, 0);
		$display("test lowvolt done");
		rd(`MIFC_OFS_STAT, e_st, "status");
		wr(`MIFC_OFS_MASK, 0);
		@(posedge hclk);
		chk("irq", irq, 0);
		wr(`MIFC_OFS_MASK, 7);
		@(posedge hclk);
		chk("irq", irq, e_st != 0);
		rd(`MIFC_OFS_MASK, 7, "mask");
		wr(`MIFC_OFS_STAT, 7);
		@(posedge hclk);
		rd(`MIFC_OFS_STAT, 0, "status");
		chk("irq", irq, 0);
		$display("test irq done");
		complete_run;
	end
endmodule // testbench
